// file: common/hdio_pkg.sv
// package for the host direct register access slave port
package hdio_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 40;
   // time to carry a command/status write onto the adapter internal bus
   localparam int CMD_SYNC_NS = 500;
   localparam int CMD_SYNC_CYCLES = (CMD_SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CMD_SYNC_LOAD = CMD_SYNC_CYCLES[3:0];
   localparam logic [3:0] CMD_SYNC_IDLE = 4'h0;

   // word indices formed from bank select and the two low select bits
   localparam logic [2:0] IDX_HOST_CMD_STS = 3'h0;
   localparam logic [2:0] IDX_DATA_WINDOW = 3'h1;
   localparam logic [2:0] IDX_WINDOW_ADDR = 3'h2;

   // field positions
   localparam int SEL_BYTE_BIT = 2;
   localparam int LANE_HI_MSB = 15;
   localparam int LANE_HI_LSB = 8;

   // reset values and byte enable codes
   localparam logic [15:0] BUS_RESET = 16'h0000;
   localparam logic [1:0] BE_NONE = 2'h0;
   localparam logic [1:0] BE_LOW = 2'h1;
   localparam logic [1:0] BE_HIGH = 2'h2;
   localparam logic [1:0] BE_BOTH = 2'h3;

   // latched select inputs
   typedef struct packed {
      logic cs_n;
      logic bhe_n;
      logic bank;
      logic [2:0] bits;
   } hdio_sel_s;

   // request towards the adapter register file
   typedef struct packed {
      logic [2:0] index;
      logic [1:0] byte_en;
      logic [15:0] data;
   } hdio_req_s;

   // port states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_RD_FETCH = 4'h1,
      ST_RD_DRIVE = 4'h2,
      ST_RD_READY = 4'h3,
      ST_RD_RELEASE = 4'h4,
      ST_WR_DIR = 4'h5,
      ST_WR_WAIT = 4'h6,
      ST_WR_READY = 4'h7,
      ST_WR_RELEASE = 4'h8,
      ST_WR_DIR_OFF = 4'h9,
      ST_ACK_FIRST = 4'hA,
      ST_ACK_GAP = 4'hB
   } hdio_state_e;

   // odd parity bit for one byte lane
   function automatic logic odd_parity(input logic [7:0] b);
      odd_parity = ~(^b);
   endfunction
endpackage

// file: core/hdio_lane_mux.sv
// lane steering for host reads and writes
`timescale 1ns/1ps
module hdio_lane_mux
   import hdio_pkg::*;
(
   // access shape
   input wire logic mode_8bit,
   input wire logic bhe_n,
   input wire logic byte_sel,
   // read path
   input wire logic [15:0] word_in,
   output logic [15:0] lanes_out,
   output logic [1:0] parity_out,
   // write path
   input wire logic [15:0] lanes_in,
   output logic [15:0] word_out,
   output logic [1:0] byte_en
);
   logic [7:0] msb;
   logic [7:0] lsb;

   // read: unused lane still carries stable data and parity
   always_comb begin
      msb = word_in[LANE_HI_MSB:LANE_HI_LSB];
      lsb = word_in[7:0];
      lanes_out = {msb, lsb};
      if (mode_8bit) begin
         lanes_out = {msb, (byte_sel ? msb : lsb)};
      end else if (bhe_n && !byte_sel) begin
         lanes_out = {msb, msb};
      end
      parity_out = {odd_parity(lanes_out[15:8]), odd_parity(lanes_out[7:0])};
   end

   // write: pick lanes and byte enables; illegal combination writes nothing
   always_comb begin
      word_out = lanes_in;
      byte_en = BE_NONE;
      if (mode_8bit) begin
         word_out = {lanes_in[7:0], lanes_in[7:0]};
         byte_en = byte_sel ? BE_HIGH : BE_LOW;
      end else begin
         case ({bhe_n, byte_sel})
            2'b00: byte_en = BE_BOTH;
            2'b01: byte_en = BE_HIGH;
            2'b10: byte_en = BE_LOW;
            default: byte_en = BE_NONE;
         endcase
      end
   end
endmodule

// file: core/hdio_port.sv
// host direct register access slave port, separate read/write strobe mode
`timescale 1ns/1ps
module hdio_port
   import hdio_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // strap
   input wire logic mode_8bit,
   // host control pins
   input wire logic host_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic vector_ack_n,
   input wire logic select_latch_strobe,
   input wire logic byte_high_enable_n,
   input wire logic register_bank_select,
   input wire logic [2:0] register_select_bits,
   // shared address/data bus, both lanes
   input wire logic [15:0] shared_addr_data_bus_in,
   output logic [15:0] shared_addr_data_bus_out,
   output logic [1:0] lane_parity_out,
   output logic shared_addr_data_bus_oe_n,
   // ready pin, driven high on release, then floated to the pull-up
   input wire logic access_ready_n_in,
   output logic access_ready_n_out,
   output logic access_ready_oe_n,
   // transceiver controls
   output logic transceiver_direction,
   output logic transceiver_enable_n,
   // adapter register file
   output logic reg_rd_req,
   output logic reg_wr_req,
   output hdio_req_s reg_req,
   input wire logic [15:0] reg_rd_data,
   // adapter side events
   input wire logic [7:0] interrupt_vector_reg,
   input wire logic window_done,
   output logic window_busy,
   output logic cmd_sync_busy
);
   hdio_state_e state_reg, state_next;
   hdio_sel_s sel_reg, sel_next;
   hdio_req_s req_reg, req_next;
   logic [15:0] bus_out_reg, bus_out_next;
   logic [1:0] par_reg, par_next;
   logic bus_oe_n_reg, bus_oe_n_next;
   logic rdy_out_reg, rdy_out_next;
   logic rdy_oe_n_reg, rdy_oe_n_next;
   logic dir_reg, dir_next;
   logic en_n_reg, en_n_next;
   logic rd_req_reg, rd_req_next;
   logic wr_req_reg, wr_req_next;
   logic win_busy_reg, win_busy_next;
   logic [3:0] sync_cnt_reg, sync_cnt_next;
   logic vec_cycle_reg, vec_cycle_next;
   logic [15:0] wr_hold_reg, wr_hold_next;

   logic [15:0] mux_lanes;
   logic [1:0] mux_par;
   logic [15:0] mux_word;
   logic [1:0] mux_be;
   logic [15:0] fetch_word;
   logic [2:0] word_idx;
   logic sel_cs_n;
   logic sync_busy;
   logic rd_hold;
   logic wr_hold;
   logic rd_start;
   logic wr_start;

   // steering works off the latched selects; vector reads are low lane only
   hdio_lane_mux u_lane_mux (
      .mode_8bit(mode_8bit | vec_cycle_reg),
      .bhe_n(sel_reg.bhe_n),
      .byte_sel(sel_reg.bits[SEL_BYTE_BIT] & ~vec_cycle_reg),
      .word_in(fetch_word),
      .lanes_out(mux_lanes),
      .parity_out(mux_par),
      .lanes_in(wr_hold_reg),
      .word_out(mux_word),
      .byte_en(mux_be)
   );

   // access qualification
   always_comb begin
      // latch output: live pins while transparent, so holds judge the new index
      word_idx = {sel_next.bank, sel_next.bits[1:0]};
      fetch_word = vec_cycle_reg ? {8'h00, interrupt_vector_reg} : reg_rd_data;
      sel_cs_n = sel_next.cs_n;
      sync_busy = (sync_cnt_reg != CMD_SYNC_IDLE);
      // data window read waits for reload or memory write
      rd_hold = sync_busy | (win_busy_reg & (word_idx == IDX_DATA_WINDOW));
      // write to address or data window waits for window work
      wr_hold = sync_busy | (win_busy_reg & ((word_idx == IDX_DATA_WINDOW) |
                                              (word_idx == IDX_WINDOW_ADDR)));
      rd_start = ~sel_cs_n & ~host_read_strobe_n;
      wr_start = ~sel_cs_n & ~host_write_strobe_n;
   end

   // select latch: transparent in idle while strobe high; start edge takes live pins
   always_comb begin
      sel_next = sel_reg;
      if (select_latch_strobe && state_reg == ST_IDLE) begin
         sel_next.cs_n = host_select_n;
         sel_next.bhe_n = mode_8bit ? 1'b1 : byte_high_enable_n;
         sel_next.bank = register_bank_select;
         sel_next.bits = register_select_bits;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_reg <= '{cs_n: 1'b1, bhe_n: 1'b1, bank: 1'b0, bits: 3'h0};
      end else begin
         sel_reg <= sel_next;
      end
   end

   // main access sequencer
   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      bus_out_next = bus_out_reg;
      par_next = par_reg;
      bus_oe_n_next = bus_oe_n_reg;
      rdy_out_next = rdy_out_reg;
      rdy_oe_n_next = rdy_oe_n_reg;
      dir_next = dir_reg;
      en_n_next = en_n_reg;
      rd_req_next = 1'b0;
      wr_req_next = 1'b0;
      win_busy_next = win_busy_reg & ~window_done;
      sync_cnt_next = sync_busy ? sync_cnt_reg - 4'h1 : sync_cnt_reg;
      vec_cycle_next = vec_cycle_reg;
      wr_hold_next = wr_hold_reg;
      case (state_reg)
         ST_IDLE: begin
            // idle pins: bus floats, direction and enable high, ready floats
            bus_oe_n_next = 1'b1;
            rdy_oe_n_next = 1'b1;
            dir_next = 1'b1;
            en_n_next = 1'b1;
            vec_cycle_next = 1'b0;
            if (!vector_ack_n && host_select_n) begin
               state_next = ST_ACK_FIRST;
            end else if (wr_start) begin
               dir_next = 1'b0;
               state_next = ST_WR_DIR;
            end else if (rd_start && !rd_hold) begin
               req_next.index = {register_bank_select, register_select_bits[1:0]};
               if (!select_latch_strobe) begin
                  req_next.index = {sel_reg.bank, sel_reg.bits[1:0]};
               end
               rd_req_next = 1'b1;
               state_next = ST_RD_FETCH;
            end
         end
         ST_RD_FETCH: begin
            // register file answers one cycle after the request
            state_next = ST_RD_DRIVE;
            if (!vec_cycle_reg && word_idx == IDX_DATA_WINDOW) begin
               win_busy_next = 1'b1;
            end
         end
         ST_RD_DRIVE: begin
            bus_out_next = mux_lanes;
            par_next = mux_par;
            bus_oe_n_next = 1'b0;
            en_n_next = 1'b0;
            dir_next = 1'b1;
            state_next = ST_RD_READY;
         end
         ST_RD_READY: begin
            // data has stood a cycle before ready falls
            if (vec_cycle_reg ? vector_ack_n : (host_read_strobe_n | host_select_n)) begin
               en_n_next = 1'b1;
               rdy_out_next = 1'b1;
               rdy_oe_n_next = 1'b0;
               bus_oe_n_next = 1'b1;
               state_next = ST_RD_RELEASE;
            end else begin
               rdy_out_next = 1'b0;
               rdy_oe_n_next = 1'b0;
            end
         end
         ST_RD_RELEASE: begin
            // float ready once the pin reads back high
            if (access_ready_n_in) begin
               rdy_oe_n_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_WR_DIR: begin
            // direction seen with strobe still low: open transceiver
            if (host_write_strobe_n) begin
               dir_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               en_n_next = 1'b0;
               state_next = ST_WR_WAIT;
            end
         end
         ST_WR_WAIT: begin
            wr_hold_next = shared_addr_data_bus_in;
            if (host_write_strobe_n || sel_reg.cs_n) begin
               en_n_next = 1'b1;
               state_next = ST_WR_DIR_OFF;
            end else if (!wr_hold) begin
               rdy_out_next = 1'b0;
               rdy_oe_n_next = 1'b0;
               state_next = ST_WR_READY;
            end
         end
         ST_WR_READY: begin
            if (host_write_strobe_n || host_select_n) begin
               // strobe gone: commit data captured while it was low
               req_next.index = word_idx;
               req_next.data = mux_word;
               req_next.byte_en = mux_be;
               wr_req_next = 1'b1;
               if (word_idx == IDX_DATA_WINDOW ||
                   (word_idx == IDX_WINDOW_ADDR && mux_be[1])) begin
                  win_busy_next = 1'b1;
               end
               if (word_idx == IDX_HOST_CMD_STS) begin
                  sync_cnt_next = CMD_SYNC_LOAD;
               end
               en_n_next = 1'b1;
               rdy_out_next = 1'b1;
               state_next = ST_WR_RELEASE;
            end else begin
               wr_hold_next = shared_addr_data_bus_in;
            end
         end
         ST_WR_RELEASE: begin
            // direction stays low one cycle past enable
            dir_next = 1'b1;
            if (access_ready_n_in) begin
               rdy_oe_n_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               state_next = ST_WR_DIR_OFF;
            end
         end
         ST_WR_DIR_OFF: begin
            dir_next = 1'b1;
            if (access_ready_n_in) begin
               rdy_oe_n_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_ACK_FIRST: begin
            // first pulse drives nothing; selects are ignored
            if (vector_ack_n) begin
               state_next = ST_ACK_GAP;
            end
         end
         ST_ACK_GAP: begin
            if (!vector_ack_n) begin
               vec_cycle_next = 1'b1;
               state_next = ST_RD_FETCH;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // a completion in the same cycle as a new trigger leaves busy set
      if (window_done && state_reg != ST_RD_FETCH && state_reg != ST_WR_READY) begin
         win_busy_next = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         req_reg <= '{index: 3'h0, byte_en: BE_NONE, data: BUS_RESET};
         bus_out_reg <= BUS_RESET;
         par_reg <= 2'h3;
         bus_oe_n_reg <= 1'b1;
         rdy_out_reg <= 1'b1;
         rdy_oe_n_reg <= 1'b1;
         dir_reg <= 1'b1;
         en_n_reg <= 1'b1;
         rd_req_reg <= 1'b0;
         wr_req_reg <= 1'b0;
         win_busy_reg <= 1'b0;
         sync_cnt_reg <= CMD_SYNC_IDLE;
         vec_cycle_reg <= 1'b0;
         wr_hold_reg <= BUS_RESET;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         bus_out_reg <= bus_out_next;
         par_reg <= par_next;
         bus_oe_n_reg <= bus_oe_n_next;
         rdy_out_reg <= rdy_out_next;
         rdy_oe_n_reg <= rdy_oe_n_next;
         dir_reg <= dir_next;
         en_n_reg <= en_n_next;
         rd_req_reg <= rd_req_next;
         wr_req_reg <= wr_req_next;
         win_busy_reg <= win_busy_next;
         sync_cnt_reg <= sync_cnt_next;
         vec_cycle_reg <= vec_cycle_next;
         wr_hold_reg <= wr_hold_next;
      end
   end

   // outputs straight from flops, cmd_sync_busy decoded from the sync counter; no interrupt output is touched here
   assign shared_addr_data_bus_out = bus_out_reg;
   assign lane_parity_out = par_reg;
   assign shared_addr_data_bus_oe_n = bus_oe_n_reg;
   assign access_ready_n_out = rdy_out_reg;
   assign access_ready_oe_n = rdy_oe_n_reg;
   assign transceiver_direction = dir_reg;
   assign transceiver_enable_n = en_n_reg;
   assign reg_rd_req = rd_req_reg;
   assign reg_wr_req = wr_req_reg;
   assign reg_req = req_reg;
   assign window_busy = win_busy_reg;
   assign cmd_sync_busy = (sync_cnt_reg != CMD_SYNC_IDLE);
endmodule

// file: bench/hdio_port_chk.sv
// pin-level assertions for the host direct register access port
`timescale 1ns/1ps
module hdio_port_chk
   import hdio_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host pins
   input wire logic host_select_n,
   input wire logic host_write_strobe_n,
   input wire logic host_read_strobe_n,
   input wire logic vector_ack_n,
   input wire logic access_ready_n_in,
   // device pins
   input wire logic [15:0] shared_addr_data_bus_out,
   input wire logic [1:0] lane_parity_out,
   input wire logic shared_addr_data_bus_oe_n,
   input wire logic access_ready_n_out,
   input wire logic access_ready_oe_n,
   input wire logic transceiver_direction,
   input wire logic transceiver_enable_n,
   // adapter side
   input wire logic reg_rd_req,
   input wire logic reg_wr_req,
   input wire hdio_req_s reg_req,
   input wire logic window_busy,
   input wire logic cmd_sync_busy
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ready held low by the device, split by transfer direction
   wire rdy_rd = !access_ready_oe_n && !access_ready_n_out && transceiver_direction;
   wire rdy_wr = !access_ready_oe_n && !access_ready_n_out && !transceiver_direction;
   // write opening: host request seen in idle, then direction, then transceiver
   sequence s_wr_take;
      !host_write_strobe_n && !host_select_n && !cmd_sync_busy && transceiver_direction
         && transceiver_enable_n && access_ready_oe_n;
   endsequence
   sequence s_wr_open;
      !transceiver_direction ##1 !transceiver_enable_n;
   endsequence
   a_parity_odd: assert property (!shared_addr_data_bus_oe_n |->
      lane_parity_out == {~^shared_addr_data_bus_out[15:8], ~^shared_addr_data_bus_out[7:0]})
      else $error("driven lane parity not odd");
   a_read_drive: assert property (!shared_addr_data_bus_oe_n |-> !transceiver_enable_n && transceiver_direction)
      else $error("bus driven without transceiver on towards host");
   a_ready_after_data: assert property (rdy_rd |-> !shared_addr_data_bus_oe_n && !$past(shared_addr_data_bus_oe_n))
      else $error("read ready before data valid");
   a_read_release: assert property (rdy_rd && host_read_strobe_n && vector_ack_n |=>
      transceiver_enable_n && access_ready_n_out)
      else $error("read not released after strobe high");
   a_ready_float: assert property (!access_ready_oe_n && access_ready_n_out && access_ready_n_in |->
      ##[1:2] access_ready_oe_n)
      else $error("ready not floated after seen high");
   a_write_open: assert property (s_wr_take |=> s_wr_open)
      else $error("write direction and enable out of order");
   a_write_commit: assert property (reg_wr_req |-> transceiver_enable_n && !transceiver_direction && $past(rdy_wr))
      else $error("write commit without ready or direction released early");
   a_sync_hold: assert property (reg_rd_req |-> !$past(cmd_sync_busy))
      else $error("read started during command sync");
   a_window_hold: assert property (reg_rd_req && reg_req.index == IDX_DATA_WINDOW |-> !$past(window_busy))
      else $error("window read started while window busy");
endmodule
bind hdio_port hdio_port_chk u_chk (.clk, .rst, .host_select_n, .host_write_strobe_n, .host_read_strobe_n,
   .vector_ack_n, .access_ready_n_in, .shared_addr_data_bus_out, .lane_parity_out, .shared_addr_data_bus_oe_n,
   .access_ready_n_out, .access_ready_oe_n, .transceiver_direction, .transceiver_enable_n, .reg_rd_req,
   .reg_wr_req, .reg_req, .window_busy, .cmd_sync_busy);

// file: bench/hdio_host_model.sv
// host processor model driving the separate-strobe register port
`timescale 1ns/1ps
module hdio_host_model
   import hdio_pkg::*;
(
   // clock
   input wire logic clk,
   // host control pins
   output logic host_select_n,
   output logic host_read_strobe_n,
   output logic host_write_strobe_n,
   output logic vector_ack_n,
   output logic select_latch_strobe,
   output logic [4:0] addr_pins,
   // resolved bus and ready pins
   input wire logic [15:0] shared_addr_data_bus_out,
   input wire logic shared_addr_data_bus_oe_n,
   output logic [15:0] shared_addr_data_bus_in,
   input wire logic access_ready_n_out,
   input wire logic access_ready_oe_n,
   output logic access_ready_n_in
);
   logic drive_en = 1'h0;
   logic [15:0] drive_val = 16'h0000;
   logic [15:0] last_bus = 16'h0000;
   logic timed_out = 1'h0;
   logic quiet = 1'h1;
   // floated ready reads high through the pull-up
   assign access_ready_n_in = access_ready_oe_n ? 1'h1 : access_ready_n_out;
   // an undriven bus flips every cycle so stale data never looks valid
   assign shared_addr_data_bus_in = !shared_addr_data_bus_oe_n ? shared_addr_data_bus_out :
      (drive_en ? drive_val : ~last_bus);
   always @(posedge clk) last_bus <= shared_addr_data_bus_in;
   // idle host: everything negated, latch transparent
   initial begin
      {host_select_n, host_read_strobe_n, host_write_strobe_n, vector_ack_n, select_latch_strobe} = 5'h1F;
      addr_pins = 5'h00;
   end
   // bounded wait for ready low at the pin
   task automatic wait_ready(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (access_ready_n_in !== 1'h0 && n < 200);
      if (access_ready_n_in !== 1'h0) timed_out = 1'h1;
   endtask
   // one access; opt[0] latches the selects, opt[1] brings select after the strobe
   task automatic access(input logic [1:0] opt, input logic wr, input logic [4:0] a, input logic [15:0] wd,
                         output logic [15:0] rd, output int lat);
      @(posedge clk);
      #1;
      addr_pins = a;
      drive_en = wr;
      drive_val = wd;
      host_select_n = opt[1];
      if (opt[0]) begin
         @(posedge clk);
         #1;
         select_latch_strobe = 1'h0;
         @(posedge clk);
         #1;
         addr_pins = ~a;
      end
      if (wr) host_write_strobe_n = 1'h0;
      else host_read_strobe_n = 1'h0;
      if (opt[1]) begin
         repeat (2) @(posedge clk);
         #1;
         host_select_n = 1'h0;
      end
      wait_ready(lat);
      rd = shared_addr_data_bus_in;
      #1;
      {host_select_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
      @(posedge clk);
      #1;
      addr_pins = 5'h00;
      select_latch_strobe = 1'h1;
      @(posedge clk);
      #1;
      drive_en = 1'h0;
      repeat (4) @(posedge clk);
   endtask
   // two acknowledge pulses, select and strobes kept negated
   task automatic ack_pair(output logic [7:0] vec);
      int n;
      quiet = 1'h1;
      #1;
      vector_ack_n = 1'h0;
      repeat (6) begin
         @(posedge clk);
         if (shared_addr_data_bus_oe_n !== 1'h1 || access_ready_oe_n !== 1'h1) quiet = 1'h0;
      end
      #1;
      vector_ack_n = 1'h1;
      repeat (3) @(posedge clk);
      #1;
      vector_ack_n = 1'h0;
      wait_ready(n);
      vec = shared_addr_data_bus_in[7:0];
      #1;
      vector_ack_n = 1'h1;
      repeat (4) @(posedge clk);
   endtask
endmodule

// file: bench/hdio_port_bench.sv
// self-checking bench for the host direct register access port
`timescale 1ns/1ps
module hdio_port_bench
   import hdio_pkg::*;
;
   logic clk, rst, mode_8bit, host_select_n, host_read_strobe_n, host_write_strobe_n, vector_ack_n;
   logic select_latch_strobe, shared_addr_data_bus_oe_n, access_ready_n_in, access_ready_n_out;
   logic access_ready_oe_n, transceiver_direction, transceiver_enable_n, reg_rd_req, reg_wr_req;
   logic window_busy, cmd_sync_busy;
   logic [4:0] addr_pins;
   logic [15:0] shared_addr_data_bus_in, shared_addr_data_bus_out, reg_rd_data;
   logic [1:0] lane_parity_out;
   logic [7:0] interrupt_vector_reg;
   hdio_req_s reg_req;
   logic [15:0] regf [8];
   logic window_done = 1'h0;
   int win_cnt = 0;
   int bad_count = 0;
   int num_checks = 0;
   int base_rd;
   int base_wr;
   hdio_port dut (.clk, .rst, .mode_8bit, .host_select_n, .host_read_strobe_n, .host_write_strobe_n,
      .vector_ack_n, .select_latch_strobe, .byte_high_enable_n(addr_pins[4]), .register_bank_select(addr_pins[3]),
      .register_select_bits(addr_pins[2:0]), .shared_addr_data_bus_in, .shared_addr_data_bus_out, .lane_parity_out,
      .shared_addr_data_bus_oe_n, .access_ready_n_in, .access_ready_n_out, .access_ready_oe_n,
      .transceiver_direction, .transceiver_enable_n, .reg_rd_req, .reg_wr_req, .reg_req, .reg_rd_data,
      .interrupt_vector_reg, .window_done, .window_busy, .cmd_sync_busy);
   hdio_host_model u_host (.clk, .host_select_n, .host_read_strobe_n, .host_write_strobe_n, .vector_ack_n,
      .select_latch_strobe, .addr_pins, .shared_addr_data_bus_out, .shared_addr_data_bus_oe_n,
      .shared_addr_data_bus_in, .access_ready_n_out, .access_ready_oe_n, .access_ready_n_in);
   // adapter register file, answering from the index the port holds
   assign reg_rd_data = regf[reg_req.index];
   always @(posedge clk) begin
      if (reg_wr_req && reg_req.byte_en[0]) regf[reg_req.index][7:0] <= reg_req.data[7:0];
      if (reg_wr_req && reg_req.byte_en[1]) regf[reg_req.index][15:8] <= reg_req.data[15:8];
   end
   // slow window engine so held accesses are clearly longer
   always @(posedge clk) begin
      win_cnt <= window_busy ? win_cnt + 1 : 0;
      window_done <= (win_cnt == 20);
   end
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // a hung handshake ends the run
   task automatic hang_cut;
      if (u_host.timed_out) begin
         bad_count++;
         report_and_stop();
      end
   endtask
   task automatic acc(input logic [1:0] opt, input logic wr, input logic [4:0] a, input logic [15:0] wd,
                      output logic [15:0] rd, output int lat);
      u_host.access(opt, wr, a, wd, rd, lat);
      hang_cut();
   endtask
   // lane expectations; address bits are {high enable, bank, byte select, index}
   function automatic logic [15:0] rd_mask(input logic m8, input logic [4:0] a);
      rd_mask = (m8 || a[4]) ? 16'h00FF : (a[2] ? 16'hFF00 : 16'hFFFF);
   endfunction
   function automatic logic [15:0] wr_exp(input logic m8, input logic [4:0] a, input logic [15:0] o, d);
      wr_exp = o;
      if (m8 && a[2]) wr_exp[15:8] = d[7:0];
      if (m8 && !a[2]) wr_exp[7:0] = d[7:0];
      if (!m8 && !a[4]) wr_exp[15:8] = d[15:8];
      if (!m8 && !a[2]) wr_exp[7:0] = d[7:0];
   endfunction
   task automatic t_lanes(input logic m);
      logic [15:0] rd, e, r;
      logic [4:0] a;
      int lat;
      @(posedge clk);
      #1;
      mode_8bit = m;
      for (int c = 0; c < 4; c++) begin
         a = {c[1], 1'h0, c[0], 2'h3};
         regf[3] = 16'h5AA5;
         e = wr_exp(m, a, 16'h5AA5, 16'hC33C);
         acc(2'h0, 1'h1, a, 16'hC33C, rd, lat);
         base_wr = lat;
         check("written word", regf[3], e);
         if (m || c != 3) begin
            acc(2'h0, 1'h0, a, 16'h0000, rd, lat);
            base_rd = lat;
            r = {e[15:8], ((m ? a[2] : a[4]) ? e[15:8] : e[7:0])};
            check("read lanes", rd & rd_mask(m, a), r & rd_mask(m, a));
         end
      end
   endtask
   task automatic t_latch;
      logic [15:0] rd;
      int lat;
      regf[3] = 16'h1E2D;
      regf[4] = 16'hFFFF;
      acc(2'h1, 1'h0, 5'h03, 16'h0000, rd, lat);
      check("latched read", rd, 16'h1E2D);
      acc(2'h2, 1'h0, 5'h03, 16'h0000, rd, lat);
      check("late select read", rd, 16'h1E2D);
   endtask
   task automatic t_cmd_sync;
      logic [15:0] rd;
      int lat;
      acc(2'h0, 1'h1, 5'h00, 16'h0F0E, rd, lat);
      check("sync busy", {15'h0, cmd_sync_busy}, 16'h0001);
      acc(2'h0, 1'h0, 5'h00, 16'h0000, rd, lat);
      check("held command read", {15'h0, lat > base_rd}, 16'h0001);
      check("command word", rd, 16'h0F0E);
   endtask
   task automatic t_window;
      logic [15:0] rd;
      int lat;
      acc(2'h0, 1'h1, 5'h06, 16'h1200, rd, lat);
      check("busy after address write", {15'h0, window_busy}, 16'h0001);
      acc(2'h0, 1'h0, 5'h01, 16'h0000, rd, lat);
      check("held window read", {15'h0, lat > base_rd}, 16'h0001);
      check("busy after window read", {15'h0, window_busy}, 16'h0001);
      acc(2'h0, 1'h1, 5'h01, 16'hBEEF, rd, lat);
      check("held window write", {15'h0, lat > base_wr}, 16'h0001);
      check("busy after window write", {15'h0, window_busy}, 16'h0001);
      for (int i = 0; i < 60 && window_busy !== 1'h0; i++) @(posedge clk);
      acc(2'h0, 1'h1, 5'h12, 16'h0034, rd, lat);
      check("idle after low address byte", {15'h0, window_busy}, 16'h0000);
   endtask
   task automatic t_ack;
      logic [7:0] vec;
      #1;
      interrupt_vector_reg = 8'hC3;
      repeat (2) @(posedge clk);
      u_host.ack_pair(vec);
      hang_cut();
      check("quiet first pulse", {15'h0, u_host.quiet}, 16'h0001);
      check("vector", {8'h00, vec}, 16'h00C3);
   endtask
   initial begin
      rst = 1'h1;
      mode_8bit = 1'h0;
      interrupt_vector_reg = 8'h00;
      for (int i = 0; i < 8; i++) regf[i] = 16'h0000;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'h0;
      check("idle pins", {12'h000, shared_addr_data_bus_oe_n, access_ready_oe_n, transceiver_direction,
         transceiver_enable_n}, 16'h000F);
      t_lanes(1'h0);
      t_latch();
      t_cmd_sync();
      t_window();
      t_lanes(1'h1);
      t_ack();
      report_and_stop();
   end
endmodule
